// ### core/gdfr_defines.svh
// Constants of the gate driver fault response: indices, defaults, offsets, timing
`ifndef GDFR_DEFINES_SVH
`define GDFR_DEFINES_SVH

// Fault indices
`define GDFR_NF           10
`define GDFR_F_CEOV       0
`define GDFR_F_PRI_BIST   1
`define GDFR_F_SEC_BIST   2
`define GDFR_F_PRI_LINK   3
`define GDFR_F_SEC_LINK   4
`define GDFR_F_LOGIC_OC   5
`define GDFR_F_SEC_OC     6
`define GDFR_F_REF        7
`define GDFR_F_SPI        8
`define GDFR_F_CFG_CRC    9

// Config word per fault: [3] warning route, [2] alarm route, [1:0] action
`define GDFR_CFG_W        4
`define GDFR_CFG_ACT_LSB  0
`define GDFR_CFG_ALARM    2
`define GDFR_CFG_WARN     3
`define GDFR_CFG_DEFAULTS 40'h4A26640CC3

// Recovery classes, one bit per fault
`define GDFR_NEED_PRI     10'h33E
`define GDFR_NEED_SEC     10'h25E
`define GDFR_NEED_CMD     10'h081
`define GDFR_NEED_REF     10'h080

// Controller register map
`define GDFR_REG_CTRL     8'h00
`define GDFR_REG_STATUS   8'h04
`define GDFR_REG_INT_STAT 8'h08
`define GDFR_REG_INT_MASK 8'h0C
`define GDFR_REG_CFG_BASE 8'h10
`define GDFR_REG_CFG_LAST 8'h34
`define GDFR_CTRL_AUTO    0
`define GDFR_CTRL_PUSH    1
`define GDFR_INT_ALARM    0
`define GDFR_INT_WARN     1
`define GDFR_INT_DONE     2

// Timing
`define GDFR_CLK_NS       4
`define GDFR_OFF_NS       400
`define GDFR_SETTLE_NS    200
`define GDFR_OFF_CYC      (`GDFR_OFF_NS / `GDFR_CLK_NS)
`define GDFR_SETTLE_CYC   (`GDFR_SETTLE_NS / `GDFR_CLK_NS)

`endif

// ### core/gdfr_pkg.sv
// Types shared by both ends of the fault response link
package gdfr_pkg;

	// Forced driver reaction
	typedef enum logic [1:0] {
		GDFR_ACT_PULL_LOW = 2'b00,
		GDFR_ACT_HIGH_IMP = 2'b01,
		GDFR_ACT_NONE     = 2'b10,
		GDFR_ACT_SOFT_OFF = 2'b11
	} gdfr_action_t;

	// Recovery sequencer of the controller
	typedef enum logic [2:0] {
		GDFR_H_IDLE   = 3'b000,
		GDFR_H_OFF    = 3'b001,
		GDFR_H_SETTLE = 3'b010,
		GDFR_H_WRITE  = 3'b011,
		GDFR_H_CLEAR  = 3'b100,
		GDFR_H_DONE   = 3'b101
	} gdfr_hstate_t;

endpackage

// ### core/gdfr_link_if.sv
// Pins between the gate driver fault logic and its host controller
`timescale 1ns/1ps
`default_nettype none
`include "gdfr_defines.svh"
interface gdfr_link_if;
	// Open-drain fault pins, driven side
	logic                   alarm_pin_n_o;
	logic                   alarm_pin_n_oe_n;
	logic                   warning_pin_n_o;
	logic                   warning_pin_n_oe_n;
	// Resolved pin levels, pulled up when nobody drives
	logic                   alarm_pin_n;
	logic                   warning_pin_n;
	// Supplies and commands from the host
	logic                   primary_supply;
	logic                   secondary_supply;
	logic                   ref_bias;
	logic                   clear_status_command;
	logic                   cfg_wr;
	logic [3:0]             cfg_idx;
	logic [`GDFR_CFG_W-1:0] cfg_data;
	// Serial readback from the device
	logic [`GDFR_NF-1:0]    status_flags;
	logic                   spi_enabled;

	assign alarm_pin_n   = alarm_pin_n_oe_n ? 1'b1 : alarm_pin_n_o;
	assign warning_pin_n = warning_pin_n_oe_n ? 1'b1 : warning_pin_n_o;

	modport dev (
		output alarm_pin_n_o, alarm_pin_n_oe_n, warning_pin_n_o, warning_pin_n_oe_n,
		output status_flags, spi_enabled,
		input  primary_supply, secondary_supply, ref_bias, clear_status_command,
		input  cfg_wr, cfg_idx, cfg_data
	);
	modport host (
		input  alarm_pin_n, warning_pin_n, status_flags, spi_enabled,
		output primary_supply, secondary_supply, ref_bias, clear_status_command,
		output cfg_wr, cfg_idx, cfg_data
	);
endinterface
`default_nettype wire

// ### core/gdfr_device.sv
// Fault response logic of the isolated gate driver
//
// Functional notes
// RQ1 - Four driver actions; serial link enabled or disabled
// RQ2 - Per-fault control bits override action and pins
// RQ3 - Collector overvoltage: flag, soft off, no pins
// RQ4 - Self-test fault: flag, pull low, both pins
// RQ5 - Primary link fault: no alarm; secondary asserts
// RQ6 - Regulator overcurrent: alarm, no gate, serial off
// RQ7 - Host cycles both supplies, then rewrites configuration
// RQ8 - Host cycles primary only, then rewrites configuration
// RQ9 - Host cycles secondary only, then rewrites configuration
// RQ10 - Reference fault: cycle bias, then clear command
// RQ11 - Flags latch; pins low while routed flag set
`timescale 1ns/1ps
`default_nettype none
`include "gdfr_defines.svh"
module gdfr_device
	import gdfr_pkg::*;
#(
	parameter int NF = `GDFR_NF
) (
	// Clock and reset
	input  wire logic     mclk,
	input  wire logic     reset,
	// Link to the host
	gdfr_link_if.dev      link,
	// Detector events, one-cycle pulses
	input  wire logic [NF-1:0] fault_evt,
	// Driver and flag view
	output gdfr_action_t  gate_action,
	output logic [NF-1:0] fault_flags
);

	localparam int SW = 3 + 1 + 1 + 4 + `GDFR_CFG_W;
	localparam logic [NF*`GDFR_CFG_W-1:0] CFG_DEF = `GDFR_CFG_DEFAULTS;
	localparam logic [NF-1:0] NEED_PRI = `GDFR_NEED_PRI;
	localparam logic [NF-1:0] NEED_SEC = `GDFR_NEED_SEC;
	localparam logic [NF-1:0] NEED_CMD = `GDFR_NEED_CMD;
	localparam logic [NF-1:0] NEED_REF = `GDFR_NEED_REF;

	logic [SW-1:0]           pin_s1_ff;
	logic [SW-1:0]           pin_s2_ff;
	logic                    clr_d_ff;
	logic                    pri_ok;
	logic                    sec_ok;
	logic                    ref_ok;
	logic                    clr_s;
	logic                    wr_s;
	logic [3:0]              idx_s;
	logic [`GDFR_CFG_W-1:0]  data_s;
	logic                    clr_pulse;
	logic                    spi_en;
	logic [`GDFR_CFG_W-1:0]  cfg_ff [NF];
	logic [NF-1:0]           flag_ff;
	logic [NF-1:0]           seen_p_ff;
	logic [NF-1:0]           seen_s_ff;
	logic [NF-1:0]           seen_r_ff;
	logic [NF-1:0]           rec_done;
	logic [NF-1:0]           alarm_route;
	logic [NF-1:0]           warn_route;
	gdfr_action_t            nxt_action;
	gdfr_action_t            action_ff;
	logic                    alarm_oe_n_ff;
	logic                    warn_oe_n_ff;
	logic [NF-1:0]           status_ff;
	logic                    spi_en_ff;

	////////////////////////////////////////////////////////////////////////////
	// Pin inputs

	// Host pins come from outside; two flops before any use
	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			pin_s1_ff <= {link.primary_supply, link.secondary_supply, link.ref_bias,
				link.clear_status_command, link.cfg_wr, link.cfg_idx, link.cfg_data};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Unpack the synchronised pins
	assign {pri_ok, sec_ok, ref_ok, clr_s, wr_s, idx_s, data_s} = pin_s2_ff;

	// Clear command acts once per rising edge of the pin
	always_ff @(posedge mclk) begin
		if (reset) begin
			clr_d_ff <= 1'b0;
		end else begin
			clr_d_ff <= clr_s;
		end
	end

	assign clr_pulse = clr_s & ~clr_d_ff;

	////////////////////////////////////////////////////////////////////////////
	// Serial interface state

	// Lost with the primary supply; regulator overcurrent browns it out
	assign spi_en = pri_ok & ~flag_ff[`GDFR_F_LOGIC_OC]; // RQ6 RQ1

	////////////////////////////////////////////////////////////////////////////
	// Configuration, one word per fault

	// A supply cycle forgets every setting, hence the host rewrite
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NF; i++) begin
			if (reset || !pri_ok || !sec_ok) begin
				cfg_ff[i] <= CFG_DEF[i*`GDFR_CFG_W +: `GDFR_CFG_W];
			end else if (wr_s && spi_en && idx_s == 4'(i)) begin
				cfg_ff[i] <= data_s; // RQ2
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Latched flags and their recovery

	generate
		for (genvar g = 0; g < NF; g++) begin : g_flag
			// Recovery is complete when every required step was seen
			assign rec_done[g] =
				(((NEED_PRI[g] | NEED_SEC[g]) & pri_ok & sec_ok
				& (seen_p_ff[g] | ~NEED_PRI[g])
				& (seen_s_ff[g] | ~NEED_SEC[g]))
				| (NEED_CMD[g] & clr_pulse & (seen_r_ff[g] | ~NEED_REF[g]))); // RQ10 RQ11

			// A new event wins over a recovery in the same cycle
			always_ff @(posedge mclk) begin
				if (reset) begin
					flag_ff[g] <= 1'b0;
				end else if (fault_evt[g]) begin
					flag_ff[g] <= 1'b1; // RQ3 RQ4 RQ5 RQ6 RQ10
				end else if (rec_done[g]) begin
					flag_ff[g] <= 1'b0; // RQ11
				end
			end

			// Remember that a supply went down while the flag stood
			always_ff @(posedge mclk) begin
				if (reset || !flag_ff[g]) begin
					seen_p_ff[g] <= 1'b0;
					seen_s_ff[g] <= 1'b0;
					seen_r_ff[g] <= 1'b0;
				end else begin
					seen_p_ff[g] <= seen_p_ff[g] | ~pri_ok;
					seen_s_ff[g] <= seen_s_ff[g] | ~sec_ok;
					seen_r_ff[g] <= seen_r_ff[g] | ~ref_ok; // RQ10
				end
			end

			assign alarm_route[g] = cfg_ff[g][`GDFR_CFG_ALARM];
			assign warn_route[g]  = cfg_ff[g][`GDFR_CFG_WARN];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Driver reaction

	// Strongest action wins: pull low, soft off, high impedance, none
	always_comb begin
		nxt_action = GDFR_ACT_NONE;
		for (int i = 0; i < NF; i++) begin
			if (flag_ff[i]) begin
				case (gdfr_action_t'(cfg_ff[i][`GDFR_CFG_ACT_LSB +: 2]))
					GDFR_ACT_PULL_LOW: begin
						nxt_action = GDFR_ACT_PULL_LOW; // RQ4 RQ5
					end
					GDFR_ACT_SOFT_OFF: begin
						if (nxt_action != GDFR_ACT_PULL_LOW) begin
							nxt_action = GDFR_ACT_SOFT_OFF; // RQ3
						end
					end
					GDFR_ACT_HIGH_IMP: begin
						if (nxt_action == GDFR_ACT_NONE) begin
							nxt_action = GDFR_ACT_HIGH_IMP;
						end
					end
					default: begin
						nxt_action = nxt_action; // RQ6
					end
				endcase
			end
		end
	end

	// Registered so the gate sees a clean code
	always_ff @(posedge mclk) begin
		if (reset) begin
			action_ff <= GDFR_ACT_NONE;
		end else begin
			action_ff <= nxt_action; // RQ1
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault pins

	// Enable is active low: pin pulled low while a routed flag stands
	always_ff @(posedge mclk) begin
		if (reset) begin
			alarm_oe_n_ff <= 1'b1;
			warn_oe_n_ff  <= 1'b1;
		end else begin
			alarm_oe_n_ff <= ~|(flag_ff & alarm_route); // RQ11 RQ4 RQ5
			warn_oe_n_ff  <= ~|(flag_ff & warn_route); // RQ11 RQ4
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial readback

	// Flags read as zero while the serial link is down
	always_ff @(posedge mclk) begin
		if (reset) begin
			status_ff <= '0;
			spi_en_ff <= 1'b0;
		end else begin
			status_ff <= spi_en ? flag_ff : '0;
			spi_en_ff <= spi_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign link.alarm_pin_n_o      = 1'b0;
	assign link.warning_pin_n_o    = 1'b0;
	assign link.alarm_pin_n_oe_n   = alarm_oe_n_ff;
	assign link.warning_pin_n_oe_n = warn_oe_n_ff;
	assign link.status_flags       = status_ff;
	assign link.spi_enabled        = spi_en_ff;
	assign gate_action             = action_ff;
	assign fault_flags             = flag_ff;

endmodule
`default_nettype wire

// ### core/gdfr_host.sv
// Host controller: AXI4-Lite registers and fault recovery sequencer
`timescale 1ns/1ps
`default_nettype none
`include "gdfr_defines.svh"
module gdfr_host
	import gdfr_pkg::*;
#(
	parameter int NF         = `GDFR_NF,
	parameter int OFF_CYC    = `GDFR_OFF_CYC,
	parameter int SETTLE_CYC = `GDFR_SETTLE_CYC
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// AXI4-Lite slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Interrupt
	output logic             irq,
	// Link to the device
	gdfr_link_if.host        link
);

	localparam logic [NF-1:0] NEED_PRI = `GDFR_NEED_PRI;
	localparam logic [NF-1:0] NEED_SEC = `GDFR_NEED_SEC;
	localparam logic [NF-1:0] NEED_CMD = `GDFR_NEED_CMD;
	localparam logic [NF-1:0] NEED_REF = `GDFR_NEED_REF;
	localparam logic [NF*`GDFR_CFG_W-1:0] CFG_DEF = `GDFR_CFG_DEFAULTS;
	localparam int SW = NF + 3;

	logic [SW-1:0]          in_s1_ff;
	logic [SW-1:0]          in_s2_ff;
	logic [NF-1:0]          flags_s;
	logic                   alarm_s;
	logic                   warn_s;
	logic                   spi_s;
	logic                   aw_have_ff;
	logic                   w_have_ff;
	logic [7:0]             aw_addr_ff;
	logic [31:0]            w_data_ff;
	logic                   w_lane0_ff;
	logic                   do_wr;
	logic                   wr_ok;
	logic                   rd_ok;
	logic [1:0]             ctrl_ff;
	logic [2:0]             int_stat_ff;
	logic [2:0]             int_mask_ff;
	logic [`GDFR_CFG_W-1:0] shadow_ff [NF];
	logic                   push_ff;
	gdfr_hstate_t           state_ff;
	logic [15:0]            cnt_ff;
	logic [3:0]             idx_ff;
	logic                   np_ff;
	logic                   ns_ff;
	logic                   nr_ff;
	logic                   pri_ff;
	logic                   sec_ff;
	logic                   ref_ff;
	logic                   clr_ff;
	logic                   cwr_ff;
	logic [3:0]             cidx_ff;
	logic [`GDFR_CFG_W-1:0] cdat_ff;
	logic                   done_evt;
	logic                   lost_link;

	////////////////////////////////////////////////////////////////////////////
	// Pin inputs through two flops
	always_ff @(posedge mclk) begin
		if (reset) begin
			in_s1_ff <= {{NF{1'b0}}, 3'b110};
			in_s2_ff <= {{NF{1'b0}}, 3'b110};
		end else begin
			in_s1_ff <= {link.status_flags, link.alarm_pin_n, link.warning_pin_n,
				link.spi_enabled};
			in_s2_ff <= in_s1_ff;
		end
	end

	assign {flags_s, alarm_s, warn_s, spi_s} = in_s2_ff;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write: address and data taken in either order
	assign awready = ~aw_have_ff & ~bvalid;
	assign wready  = ~w_have_ff & ~bvalid;
	assign do_wr   = aw_have_ff & w_have_ff & ~bvalid;
	assign wr_ok   = aw_addr_ff <= `GDFR_REG_CFG_LAST && aw_addr_ff[1:0] == 2'b00;
	assign rd_ok   = araddr <= `GDFR_REG_CFG_LAST && araddr[1:0] == 2'b00;

	always_ff @(posedge mclk) begin
		if (reset) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff  <= 32'h00000000;
			w_lane0_ff <= 1'b0;
			bvalid     <= 1'b0;
			bresp      <= 2'b00;
		end else begin
			if (awvalid && awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_ff  <= 1'b1;
				w_data_ff  <= wdata;
				w_lane0_ff <= wstrb[0];
			end
			if (do_wr) begin
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				bvalid     <= 1'b1;
				bresp      <= wr_ok ? 2'b00 : 2'b10;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Register writes; every field lives in byte lane 0
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl_ff     <= 2'b00;
			int_mask_ff <= 3'b000;
			push_ff     <= 1'b0;
			for (int i = 0; i < NF; i++) begin
				shadow_ff[i] <= CFG_DEF[i*`GDFR_CFG_W +: `GDFR_CFG_W];
			end
		end else begin
			push_ff <= 1'b0;
			if (do_wr && wr_ok && w_lane0_ff) begin
				case (aw_addr_ff)
					`GDFR_REG_CTRL: begin
						ctrl_ff[`GDFR_CTRL_AUTO] <= w_data_ff[`GDFR_CTRL_AUTO];
						push_ff <= w_data_ff[`GDFR_CTRL_PUSH];
					end
					`GDFR_REG_INT_MASK: begin
						int_mask_ff <= w_data_ff[2:0];
					end
					default: begin
						for (int i = 0; i < NF; i++) begin
							if (aw_addr_ff == 8'(`GDFR_REG_CFG_BASE + 4 * i)) begin
								shadow_ff[i] <= w_data_ff[`GDFR_CFG_W-1:0];
							end
						end
					end
				endcase
			end
		end
	end

	// Sticky interrupt bits; a new event wins over a write-one clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			int_stat_ff <= 3'b000;
		end else begin
			for (int b = 0; b < 3; b++) begin
				if (do_wr && wr_ok && w_lane0_ff && aw_addr_ff == `GDFR_REG_INT_STAT
					&& w_data_ff[b]) begin
					int_stat_ff[b] <= 1'b0;
				end
			end
			if (!alarm_s) int_stat_ff[`GDFR_INT_ALARM] <= 1'b1;
			if (!warn_s) int_stat_ff[`GDFR_INT_WARN] <= 1'b1;
			if (done_evt) int_stat_ff[`GDFR_INT_DONE] <= 1'b1;
		end
	end

	// A set mask bit hides its source from the interrupt line
	assign irq = |(int_stat_ff & ~int_mask_ff);

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read
	assign arready = ~rvalid;

	always_ff @(posedge mclk) begin
		if (reset) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= 2'b00;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= rd_ok ? 2'b00 : 2'b10;
			rdata  <= 32'h00000000;
			case (araddr)
				`GDFR_REG_CTRL:     rdata <= 32'(ctrl_ff);
				`GDFR_REG_STATUS:   rdata <= {17'h00000, spi_s, warn_s, alarm_s,
					state_ff, 3'h0, 6'(flags_s)};
				`GDFR_REG_INT_STAT: rdata <= 32'(int_stat_ff);
				`GDFR_REG_INT_MASK: rdata <= 32'(int_mask_ff);
				default: begin
					for (int i = 0; i < NF; i++) begin
						if (araddr == 8'(`GDFR_REG_CFG_BASE + 4 * i)) begin
							rdata <= 32'(shadow_ff[i]);
						end
					end
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Recovery sequencer
	assign done_evt = state_ff == GDFR_H_DONE && cnt_ff == 16'h0000;

	// Serial lost while the alarm is low: flags cannot be read, so cycle primary
	assign lost_link = ~spi_s & ~alarm_s; // RQ8

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_ff <= GDFR_H_IDLE;
			cnt_ff   <= 16'h0000;
			idx_ff   <= 4'h0;
			{np_ff, ns_ff, nr_ff} <= 3'b000;
			{pri_ff, sec_ff, ref_ff} <= 3'b111;
			clr_ff   <= 1'b0;
			cwr_ff   <= 1'b0;
			cidx_ff  <= 4'h0;
			cdat_ff  <= '0;
		end else begin
			clr_ff <= 1'b0;
			cwr_ff <= 1'b0;
			case (state_ff)
				GDFR_H_IDLE: begin
					idx_ff <= 4'h0;
					if (push_ff) begin
						state_ff <= GDFR_H_WRITE;
					end else if (ctrl_ff[`GDFR_CTRL_AUTO] && (|flags_s || lost_link)) begin
						np_ff  <= lost_link | (|(flags_s & NEED_PRI)); // RQ7 RQ8
						ns_ff  <= |(flags_s & NEED_SEC); // RQ7 RQ9
						nr_ff  <= |(flags_s & NEED_CMD);
						pri_ff <= ~(lost_link | (|(flags_s & NEED_PRI)));
						sec_ff <= ~|(flags_s & NEED_SEC);
						ref_ff <= ~|(flags_s & NEED_REF); // RQ10
						cnt_ff <= 16'(OFF_CYC);
						state_ff <= (lost_link || |(flags_s & (NEED_PRI | NEED_SEC | NEED_REF)))
							? GDFR_H_OFF : GDFR_H_CLEAR;
					end
				end
				GDFR_H_OFF: begin
					cnt_ff <= cnt_ff - 16'h0001;
					if (cnt_ff == 16'h0001) begin
						{pri_ff, sec_ff, ref_ff} <= 3'b111;
						cnt_ff   <= 16'(SETTLE_CYC);
						state_ff <= GDFR_H_SETTLE;
					end
				end
				GDFR_H_SETTLE: begin
					cnt_ff <= cnt_ff - 16'h0001;
					if (cnt_ff == 16'h0001) begin
						state_ff <= (np_ff | ns_ff) ? GDFR_H_WRITE : GDFR_H_CLEAR;
					end
				end
				GDFR_H_WRITE: begin
					// Rewrite every configurable word once serial is back
					if (spi_s) begin
						cwr_ff  <= 1'b1; // RQ7 RQ8 RQ9
						cidx_ff <= idx_ff;
						cdat_ff <= shadow_ff[idx_ff];
						idx_ff  <= idx_ff + 4'h1;
						if (idx_ff == 4'(NF - 1)) begin
							state_ff <= nr_ff ? GDFR_H_CLEAR : GDFR_H_DONE;
							cnt_ff   <= 16'(SETTLE_CYC);
						end
					end
				end
				GDFR_H_CLEAR: begin
					clr_ff   <= 1'b1; // RQ10
					nr_ff    <= 1'b0;
					cnt_ff   <= 16'(SETTLE_CYC);
					state_ff <= GDFR_H_DONE;
				end
				GDFR_H_DONE: begin
					// Wait out pin latency so stale flags do not retrigger
					cnt_ff <= cnt_ff - 16'h0001;
					if (cnt_ff == 16'h0000) begin
						state_ff <= GDFR_H_IDLE;
					end
				end
				default: begin
					state_ff <= GDFR_H_IDLE;
				end
			endcase
		end
	end

	assign link.primary_supply       = pri_ff;
	assign link.secondary_supply     = sec_ff;
	assign link.ref_bias             = ref_ff;
	assign link.clear_status_command = clr_ff;
	assign link.cfg_wr               = cwr_ff;
	assign link.cfg_idx              = cidx_ff;
	assign link.cfg_data             = cdat_ff;

endmodule
`default_nettype wire

// ### test/gdfr_props.sv
// Checker of the fault response link
`timescale 1ns/1ps
`default_nettype none
module gdfr_props
	import gdfr_pkg::*;
(
	// Clock and reset
	input wire logic         mclk,
	input wire logic         reset,
	// Device side
	input wire logic [9:0]   fault_evt,
	input wire logic [9:0]   fault_flags,
	input wire gdfr_action_t gate_action,
	input wire logic         alarm_pin_n,
	input wire logic         warning_pin_n,
	input wire logic         spi_enabled,
	// Host side
	input wire logic         primary_supply,
	input wire logic         secondary_supply,
	input wire logic         clear_status_command
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////
	// Default reactions; all but the self-test and secondary link checks judged only from a quiet start
	a_ceov_soft: assert property (fault_evt[0] && fault_flags == 10'h000 |-> ##2
		gate_action == GDFR_ACT_SOFT_OFF && alarm_pin_n && warning_pin_n) else $error("soft off");
	a_bist_pins: assert property (fault_evt[1] || fault_evt[2] |-> ##2
		!alarm_pin_n && !warning_pin_n && gate_action == GDFR_ACT_PULL_LOW) else $error("selftest");
	a_pri_link: assert property (fault_evt[3] && fault_flags == 10'h000 |-> ##2
		alarm_pin_n && gate_action == GDFR_ACT_PULL_LOW) else $error("primary link");
	a_sec_link: assert property (fault_evt[4] |-> ##2 !alarm_pin_n) else $error("sec link");
	a_logic_oc: assert property (fault_evt[5] && fault_flags == 10'h000 |-> ##2
		!alarm_pin_n && gate_action == GDFR_ACT_NONE ##[0:2] !spi_enabled) else $error("reg oc");
	a_ref_quiet: assert property (fault_evt[7] && fault_flags == 10'h000 |-> ##2
		gate_action == GDFR_ACT_NONE && alarm_pin_n) else $error("reference");

	////////////////////////////////////////////////////////////////////////////
	// Latching, pin levels and recovery order
	a_flag_latch: assert property (|fault_evt |=>
		(fault_flags & $past(fault_evt)) == $past(fault_evt)) else $error("flag not set");
	a_ceov_hold: assert property ($fell(fault_flags[0]) |-> $past(clear_status_command, 2)
		|| $past(clear_status_command, 3) || $past(clear_status_command, 4)) else $error("ceov");
	a_alarm_pin: assert property (!alarm_pin_n == |($past(fault_flags) & 10'h276))
		else $error("alarm pin");
	a_warn_pin: assert property (!warning_pin_n == |($past(fault_flags) & 10'h106))
		else $error("warning pin");
	a_pri_keep: assert property ((fault_flags & 10'h33E) == 10'h000 |-> primary_supply)
		else $error("primary dropped");
	a_sec_keep: assert property ((fault_flags & 10'h25E) == 10'h000 |-> secondary_supply)
		else $error("secondary dropped");
endmodule
`default_nettype wire

// ### test/gate_driver_fault_response_tb_top.sv
// Bench joining device and host, walking every fault through recovery
`timescale 1ns/1ps
`default_nettype none
`include "gdfr_defines.svh"
module gate_driver_fault_response_tb_top;
	localparam logic [39:0] DEFS = `GDFR_CFG_DEFAULTS;
	logic        mclk, reset, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb, cw;
	logic [1:0]  bresp, rresp, rs, gate_action;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [9:0]  fault_evt, flags;
	int          errors, comparisons, n;
	gdfr_link_if u_link ();

	// Both ends meet on one link
	gdfr_device u_gdfr_device (.mclk, .reset, .link(u_link.dev), .fault_evt,
		.gate_action, .fault_flags(flags));
	gdfr_host #(.OFF_CYC(4), .SETTLE_CYC(8)) u_gdfr_host (.mclk, .reset, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .link(u_link.host));
	gdfr_props u_gdfr_props (.mclk, .reset, .fault_evt, .fault_flags(flags), .gate_action,
		.alarm_pin_n(u_link.alarm_pin_n), .warning_pin_n(u_link.warning_pin_n),
		.spi_enabled(u_link.spi_enabled), .primary_supply(u_link.primary_supply),
		.secondary_supply(u_link.secondary_supply),
		.clear_status_command(u_link.clear_status_command));

	// 250 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic tmo(input bit t);
		if (t) begin
			errors++;
			final_report();
		end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Each channel is released at the edge that takes it; no cycle count assumed
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && k < 99);
		r = bresp;
		bready <= 1'b0;
		tmo(k >= 99);
	endtask

	task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && k < 99);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		tmo(k >= 99);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{reset, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
		{awaddr, araddr, wdata, wstrb, fault_evt} = {16'h0000, 32'h0, 4'hF, 10'h000};
		errors = 0;
		comparisons = 0;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			rdw(8'h10 + 8'(4 * i), rd, rs);
			chk(rd, 32'(DEFS[4*i +: 4]), "config default");
		end
		rdw(8'h38, rd, rs);
		chk({rd[29:0], rs}, 32'h2, "unmapped read");
		wr(8'h38, 32'h1, rs);
		chk(32'(rs), 32'h2, "unmapped write");
		wr(`GDFR_REG_INT_MASK, 32'h0, rs);
		// Override fault 6 to high impedance, then push every word to the device
		wr(8'h28, 32'h5, rs);
		rdw(8'h28, rd, rs);
		chk(rd, 32'h5, "config write");
		wr(`GDFR_REG_CTRL, 32'h3, rs);
		$display("register test done");
		// Each fault alone: forced action, pins, serial state, then auto recovery
		for (int i = 0; i < 10; i++) begin
			cw = (i == 6) ? 4'h5 : DEFS[4*i +: 4];
			@(posedge mclk);
			fault_evt <= 10'(1) << i;
			@(posedge mclk);
			fault_evt <= 10'h000;
			repeat (2) @(posedge mclk);
			#1;
			chk(32'(gate_action), 32'(cw[1:0]), "gate action");
			chk(32'(u_link.alarm_pin_n), 32'(!cw[2]), "alarm pin");
			chk(32'(u_link.warning_pin_n), 32'(!cw[3]), "warning pin");
			chk(32'(u_link.spi_enabled), 32'(i != 5), "serial state");
			for (n = 0; n < 3000 && flags !== 10'h000; n++) @(posedge mclk);
			tmo(n >= 3000);
			repeat (40) @(posedge mclk);
			chk(32'(u_link.spi_enabled), 32'h1, "serial back");
			$display("fault %0d test done", i);
		end
		// Interrupt raised, masked and cleared
		rdw(`GDFR_REG_INT_STAT, rd, rs);
		chk(rd, 32'h7, "events seen");
		chk(32'(irq), 32'h1, "irq raised");
		wr(`GDFR_REG_INT_MASK, 32'h7, rs);
		chk(32'(irq), 32'h0, "irq masked");
		wr(`GDFR_REG_INT_STAT, 32'h7, rs);
		wr(`GDFR_REG_INT_MASK, 32'h0, rs);
		rdw(`GDFR_REG_INT_STAT, rd, rs);
		chk({rd[30:0], irq}, 32'h0, "events cleared");
		$display("interrupt test done");
		final_report();
	end
endmodule
`default_nettype wire
